/* core/opdec_pkg.sv */
// Constants, enumerations and carriers for the opcode decoder.
// Assumes one processor clock; bytes arrive in program order.
package opdec_pkg;

  localparam logic [7:0] OPC_SEG_LOAD = 8'h8E;
  localparam logic [7:0] OPC_SEG_STORE = 8'h8C;
  localparam logic [7:0] OPC_TABLE = 8'hD7;
  localparam logic [7:0] OPC_EA_LOAD = 8'h8D;
  localparam logic [7:0] OPC_PTR_DATA = 8'hC5;
  localparam logic [7:0] OPC_PTR_EXTRA = 8'hC4;
  localparam logic [7:0] OPC_FLAGS_OUT = 8'h9F;
  localparam logic [7:0] OPC_FLAGS_IN = 8'h9E;
  localparam logic [7:0] OPC_ASCII_SUM = 8'h37;
  localparam logic [7:0] OPC_BCD_SUM = 8'h27;
  localparam logic [7:0] OPC_ASCII_DIFF = 8'h3F;
  localparam logic [7:0] OPC_BCD_DIFF = 8'h2F;
  localparam logic [7:0] OPC_ASCII_PROD = 8'hD4;
  localparam logic [7:0] OPC_ASCII_QUOT = 8'hD5;
  localparam logic [7:0] ADJ_BASE = 8'h0A;
  localparam logic [7:0] OPC_BYTE_WORD = 8'h98;
  localparam logic [7:0] OPC_WORD_DOUBLE = 8'h99;

  // Opcode bit patterns of the groups (upper bits, bits 2:1, s:w); low bits are d/s/v/w flags
  localparam logic [1:0] ALU_TOP = 2'h0;
  localparam logic [1:0] ALU_ACC_LOW = 2'h2;
  localparam logic [5:0] IMM_GRP = 6'h20;
  localparam logic [6:0] MULDIV_GRP = 7'h7B;
  localparam logic [5:0] SHIFT_GRP = 6'h34;
  localparam logic [1:0] SW_WORD_IMM = 2'h1;

  // Sub-operation field values
  localparam logic [2:0] FN_ADD = 3'h0;
  localparam logic [2:0] FN_ADC = 3'h2;
  localparam logic [2:0] FN_SBB = 3'h3;
  localparam logic [2:0] FN_SUB = 3'h5;
  localparam logic [2:0] FN_CMP = 3'h7;
  localparam logic [2:0] FN_INVERT = 3'h2;
  localparam logic [2:0] FN_NEGATE = 3'h3;
  localparam logic [2:0] FN_UPROD = 3'h4;
  localparam logic [2:0] FN_SPROD = 3'h5;
  localparam logic [2:0] FN_UQUOT = 3'h6;
  localparam logic [2:0] FN_SQUOT = 3'h7;
  localparam logic [2:0] FN_LEFT = 3'h4;
  localparam logic [2:0] FN_RIGHT = 3'h5;

  localparam logic [1:0] MOD_D8 = 2'h1;
  localparam logic [1:0] MOD_D16 = 2'h2;
  localparam logic [1:0] MOD_MEM = 2'h0;
  localparam logic [2:0] RM_DIRECT = 3'h6;
  localparam logic [1:0] LEN_NONE = 2'h0;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;

  typedef enum logic [3:0] {
    st_op = 4'h1, st_modrm = 4'h2, st_tail = 4'h4, st_fix = 4'h8
  } state_t;

  typedef enum logic [4:0] {
    no_op_decoded, copy_seg_load, copy_seg_store, table_lookup_op, eff_address_load_op,
    pointer_load_data_seg, pointer_load_extra_seg, flags_to_acc_high, acc_high_to_flags,
    alu_op, ascii_sum_fix, bcd_sum_fix, ascii_diff_fix, bcd_diff_fix, unsigned_product_op,
    signed_product_op, unsigned_quotient_op, signed_quotient_op, negate_op, invert_op,
    ascii_product_fix, ascii_quotient_fix, byte_to_word_extend, word_to_double_extend,
    left_shift_op, logical_right_shift_op
  } op_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fetch_t;

  typedef struct packed {
    op_t op;
    logic [7:0] opcode;
    logic [2:0] alu_fn;
    logic word;
    logic dir;
    logic count_cl;
    logic sign_ext;
    logic has_modrm;
    logic [7:0] modrm;
    logic [1:0] seg_sel;
    logic [1:0] disp_len;
    logic [1:0] imm_len;
    logic [15:0] disp;
    logic [15:0] imm;
    logic illegal;
  } decode_t;

endpackage : opdec_pkg

/* core/cpu_opcode_decoder.sv */
// Opcode decoder: turns a byte stream into one decoded instruction record.
// Assumes fetch bytes are synchronous to mclk and each byte is offered once.
// Operation
// - 8E with addressing bit5 clear loads a segment register
// - 8C with addressing bit5 clear stores a segment register
// - D7 alone is the table lookup into the low accumulator byte
// - 8D with addressing byte loads the effective address itself
// - C5 with addressing byte loads pointer plus data segment base
// - C4 with addressing byte loads pointer plus extra segment base
// - 9F copies flags to high accumulator byte, 9E copies back
// - Add with carry from register, immediate group 010, accumulator forms
// - Subtract with borrow from register, immediate group 011, accumulator forms
// - 37 alone is the ASCII fix after addition
// - 27 alone is the packed decimal fix after addition
// - 3F alone is the ASCII fix after subtraction
// - 2F alone is the packed decimal fix after subtraction
// - Group 1111011w fields 100 and 101 give unsigned and signed product
// - Group 1111011w fields 110 and 111 give unsigned and signed quotient
// - D4 then 0A is the ASCII fix after multiplication
// - D5 then 0A is the ASCII fix before division
// - 98 alone extends the low accumulator byte to a word
// - 99 alone extends the word accumulator to a double word
// - 110100vw field 100 is left shift; v picks count, w size
// - 110100vw field 101 is logical right shift
// - 100000sw field 000 is add; second data byte only when s:w is 01
`timescale 1ns/1ns
`default_nettype none

module cpu_opcode_decoder
  import opdec_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire fetch_t fetch,
  output logic busy,
  output logic dec_valid,
  output decode_t dec
);

  state_t state_reg, state_next;
  decode_t work_reg, work_next;
  decode_t out_reg, out_next;
  logic out_valid_reg, out_valid_next;
  logic [2:0] left_reg, left_next;
  logic [1:0] idx_reg, idx_next;

  function automatic logic alu_known(input logic [2:0] fn);
    // Logical functions of this group are not decoded here
    return (fn == FN_ADD) || (fn == FN_ADC) || (fn == FN_SBB) || (fn == FN_SUB) || (fn == FN_CMP);
  endfunction : alu_known

  function automatic decode_t first_decode(input logic [7:0] b);
    decode_t d;
    d = '0;
    d.op = no_op_decoded;
    d.opcode = b;
    d.word = b[0];
    d.dir = b[1];
    d.count_cl = b[1];
    d.sign_ext = b[1];
    if (b[7:6] == ALU_TOP && !b[2]) begin
      d.op = alu_op;
      d.alu_fn = b[5:3];
      d.has_modrm = 1'b1;
      d.illegal = !alu_known(b[5:3]);
    end else if (b[7:6] == ALU_TOP && b[2:1] == ALU_ACC_LOW) begin
      d.op = alu_op;
      d.alu_fn = b[5:3];
      d.imm_len = b[0] ? LEN_TWO : LEN_ONE;
      d.illegal = !alu_known(b[5:3]);
    end else if (b[7:2] == IMM_GRP) begin
      d.op = alu_op;
      d.has_modrm = 1'b1;
      d.imm_len = (b[1:0] == SW_WORD_IMM) ? LEN_TWO : LEN_ONE;
    end else if (b[7:1] == MULDIV_GRP || b[7:2] == SHIFT_GRP) begin
      d.has_modrm = 1'b1;
    end else begin
      d.word = 1'b0;
      unique case (b)
        OPC_SEG_LOAD: begin
          d.op = copy_seg_load;
          d.has_modrm = 1'b1;
          d.word = 1'b1;
        end
        OPC_SEG_STORE: begin
          d.op = copy_seg_store;
          d.has_modrm = 1'b1;
          d.word = 1'b1;
        end
        OPC_EA_LOAD: begin
          d.op = eff_address_load_op;
          d.has_modrm = 1'b1;
          d.word = 1'b1;
        end
        OPC_PTR_DATA: begin
          d.op = pointer_load_data_seg;
          d.has_modrm = 1'b1;
          d.word = 1'b1;
        end
        OPC_PTR_EXTRA: begin
          d.op = pointer_load_extra_seg;
          d.has_modrm = 1'b1;
          d.word = 1'b1;
        end
        OPC_TABLE: d.op = table_lookup_op;
        OPC_FLAGS_OUT: d.op = flags_to_acc_high;
        OPC_FLAGS_IN: d.op = acc_high_to_flags;
        OPC_ASCII_SUM: d.op = ascii_sum_fix;
        OPC_BCD_SUM: d.op = bcd_sum_fix;
        OPC_ASCII_DIFF: d.op = ascii_diff_fix;
        OPC_BCD_DIFF: d.op = bcd_diff_fix;
        OPC_ASCII_PROD: d.op = ascii_product_fix;
        OPC_ASCII_QUOT: d.op = ascii_quotient_fix;
        OPC_BYTE_WORD: d.op = byte_to_word_extend;
        OPC_WORD_DOUBLE: begin
          d.op = word_to_double_extend;
          d.word = 1'b1;
        end
        default: d.illegal = 1'b1;
      endcase
    end
    return d;
  endfunction : first_decode

  function automatic decode_t modrm_decode(input decode_t din, input logic [7:0] m);
    decode_t d;
    d = din;
    d.modrm = m;
    d.seg_sel = m[4:3];
    if (d.opcode == OPC_SEG_LOAD || d.opcode == OPC_SEG_STORE) begin
      d.illegal = m[5];
    end else if (d.opcode[7:2] == IMM_GRP) begin
      d.alu_fn = m[5:3];
      d.illegal = !alu_known(m[5:3]);
    end else if (d.opcode[7:1] == MULDIV_GRP) begin
      unique case (m[5:3])
        FN_INVERT: d.op = invert_op;
        FN_NEGATE: d.op = negate_op;
        FN_UPROD: d.op = unsigned_product_op;
        FN_SPROD: d.op = signed_product_op;
        FN_UQUOT: d.op = unsigned_quotient_op;
        FN_SQUOT: d.op = signed_quotient_op;
        default: d.illegal = 1'b1;
      endcase
    end else if (d.opcode[7:2] == SHIFT_GRP) begin
      unique case (m[5:3])
        FN_LEFT: d.op = left_shift_op;
        FN_RIGHT: d.op = logical_right_shift_op;
        default: d.illegal = 1'b1;
      endcase
    end
    // Displacement bytes come before any immediate bytes
    if (m[7:6] == MOD_D8) begin
      d.disp_len = LEN_ONE;
    end else if (m[7:6] == MOD_D16 || (m[7:6] == MOD_MEM && m[2:0] == RM_DIRECT)) begin
      d.disp_len = LEN_TWO;
    end else begin
      d.disp_len = LEN_NONE;
    end
    return d;
  endfunction : modrm_decode

  always_comb begin
    logic [1:0] pos;
    decode_t w;
    pos = idx_reg - work_reg.disp_len;
    w = work_reg;
    state_next = state_reg;
    work_next = work_reg;
    out_next = out_reg;
    out_valid_next = 1'b0;
    left_next = left_reg;
    idx_next = idx_reg;
    unique case (state_reg)
      st_op: begin
        if (fetch.valid) begin
          w = first_decode(fetch.data);
          work_next = w;
          idx_next = '0;
          left_next = 3'(w.imm_len);
          // Unknown first byte: length unknown, so report at once
          if (w.illegal && !w.has_modrm) begin
            out_next = w;
            out_valid_next = 1'b1;
          end else if (w.op == ascii_product_fix || w.op == ascii_quotient_fix) begin
            state_next = st_fix;
          end else if (w.has_modrm) begin
            state_next = st_modrm;
          end else if (w.imm_len != LEN_NONE) begin
            state_next = st_tail;
          end else begin
            out_next = w;
            out_valid_next = 1'b1;
          end
        end
      end
      st_modrm: begin
        if (fetch.valid) begin
          w = modrm_decode(work_reg, fetch.data);
          work_next = w;
          left_next = 3'(w.disp_len) + 3'(w.imm_len);
          if (w.disp_len == LEN_NONE && w.imm_len == LEN_NONE) begin
            out_next = w;
            out_valid_next = 1'b1;
            state_next = st_op;
          end else begin
            state_next = st_tail;
          end
        end
      end
      st_tail: begin
        if (fetch.valid) begin
          if (idx_reg < work_reg.disp_len) begin
            if (idx_reg[0]) w.disp[15:8] = fetch.data;
            else w.disp[7:0] = fetch.data;
          end else if (pos[0]) begin
            w.imm[15:8] = fetch.data;
          end else begin
            w.imm[7:0] = fetch.data;
            // Single data byte with s and w both set widens by sign
            w.imm[15:8] = (w.sign_ext && w.word && w.opcode[7:2] == IMM_GRP) ? {8{fetch.data[7]}} : 8'h00;
          end
          work_next = w;
          idx_next = idx_reg + 2'h1;
          left_next = left_reg - 3'h1;
          if (left_reg == 3'h1) begin
            out_next = w;
            out_valid_next = 1'b1;
            state_next = st_op;
          end
        end
      end
      st_fix: begin
        if (fetch.valid) begin
          w.modrm = fetch.data;
          w.illegal = (fetch.data != ADJ_BASE);
          out_next = w;
          out_valid_next = 1'b1;
          state_next = st_op;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= st_op;
      work_reg <= '0;
      out_reg <= '0;
      out_valid_reg <= 1'b0;
      left_reg <= 3'h0;
      idx_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      work_reg <= work_next;
      out_reg <= out_next;
      out_valid_reg <= out_valid_next;
      left_reg <= left_next;
      idx_reg <= idx_next;
    end
  end

  assign busy = (state_reg != st_op);
  assign dec_valid = out_valid_reg;
  assign dec = out_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence take_first(logic [7:0] code);
    state_reg == st_op && fetch.valid && fetch.data == code;
  endsequence

  sequence take_fix(logic [7:0] code);
    state_reg == st_fix && fetch.valid && fetch.data == ADJ_BASE && work_reg.opcode == code;
  endsequence

  property single_p(logic [7:0] code, op_t kind);
    take_first(code) |=> dec_valid && dec.op == kind && !dec.illegal && !dec.has_modrm;
  endproperty

  seg_load_a: assert property (dec_valid && dec.opcode == OPC_SEG_LOAD && !dec.modrm[5] |-> dec.op == copy_seg_load && !dec.illegal && dec.seg_sel == dec.modrm[4:3]) else $error("segment load decode wrong");
  seg_store_a: assert property (dec_valid && dec.opcode == OPC_SEG_STORE |-> dec.op == copy_seg_store && dec.illegal == dec.modrm[5]) else $error("segment store decode wrong");
  table_lookup_a: assert property (single_p(OPC_TABLE, table_lookup_op)) else $error("table lookup missed");
  ea_load_a: assert property (dec_valid && dec.opcode == OPC_EA_LOAD |-> dec.op == eff_address_load_op && dec.has_modrm) else $error("address load wrong");
  ptr_data_a: assert property (dec_valid && dec.opcode == OPC_PTR_DATA |-> dec.op == pointer_load_data_seg && dec.word) else $error("pointer data load wrong");
  ptr_extra_a: assert property (dec_valid && dec.opcode == OPC_PTR_EXTRA |-> dec.op == pointer_load_extra_seg && dec.word) else $error("pointer extra load wrong");
  flags_out_a: assert property (single_p(OPC_FLAGS_OUT, flags_to_acc_high)) else $error("flags copy out missed");
  flags_in_a: assert property (single_p(OPC_FLAGS_IN, acc_high_to_flags)) else $error("flags copy in missed");
  carry_add_a: assert property (dec_valid && dec.op == alu_op && dec.alu_fn == FN_ADC |-> dec.opcode[7:6] == ALU_TOP && dec.opcode[5:3] == FN_ADC || dec.opcode[7:2] == IMM_GRP && dec.modrm[5:3] == FN_ADC) else $error("carry add source wrong");
  borrow_sub_a: assert property (dec_valid && dec.op == alu_op && dec.alu_fn == FN_SBB |-> dec.opcode[7:6] == ALU_TOP && dec.opcode[5:3] == FN_SBB || dec.opcode[7:2] == IMM_GRP && dec.modrm[5:3] == FN_SBB) else $error("borrow sub source wrong");
  ascii_sum_a: assert property (single_p(OPC_ASCII_SUM, ascii_sum_fix)) else $error("ascii sum fix missed");
  bcd_sum_a: assert property (single_p(OPC_BCD_SUM, bcd_sum_fix)) else $error("bcd sum fix missed");
  ascii_diff_a: assert property (single_p(OPC_ASCII_DIFF, ascii_diff_fix)) else $error("ascii diff fix missed");
  bcd_diff_a: assert property (single_p(OPC_BCD_DIFF, bcd_diff_fix)) else $error("bcd diff fix missed");
  product_a: assert property (dec_valid && dec.opcode[7:1] == MULDIV_GRP && dec.modrm[5:4] == FN_UPROD[2:1] |-> dec.op == (dec.modrm[3] ? signed_product_op : unsigned_product_op)) else $error("product decode wrong");
  quotient_a: assert property (dec_valid && dec.opcode[7:1] == MULDIV_GRP && dec.modrm[5:4] == FN_UQUOT[2:1] |-> dec.op == (dec.modrm[3] ? signed_quotient_op : unsigned_quotient_op)) else $error("quotient decode wrong");
  ascii_prod_a: assert property (take_first(OPC_ASCII_PROD) |=> state_reg == st_fix && !dec_valid) else $error("product fix did not wait");
  ascii_prod_end_a: assert property (take_fix(OPC_ASCII_PROD) |=> dec_valid && dec.op == ascii_product_fix && !dec.illegal) else $error("product fix missed");
  ascii_quot_a: assert property (take_fix(OPC_ASCII_QUOT) |=> dec_valid && dec.op == ascii_quotient_fix && !dec.illegal) else $error("quotient fix missed");
  byte_word_a: assert property (single_p(OPC_BYTE_WORD, byte_to_word_extend)) else $error("byte extend missed");
  word_double_a: assert property (single_p(OPC_WORD_DOUBLE, word_to_double_extend)) else $error("word extend missed");
  left_shift_a: assert property (dec_valid && dec.opcode[7:2] == SHIFT_GRP && dec.modrm[5:3] == FN_LEFT |-> dec.op == left_shift_op && dec.count_cl == dec.opcode[1] && dec.word == dec.opcode[0]) else $error("left shift wrong");
  right_shift_a: assert property (dec_valid && dec.opcode[7:2] == SHIFT_GRP && dec.modrm[5:3] == FN_RIGHT |-> dec.op == logical_right_shift_op) else $error("right shift wrong");
  imm_add_len_a: assert property (dec_valid && dec.opcode[7:2] == IMM_GRP |-> dec.imm_len == ((dec.opcode[1:0] == SW_WORD_IMM) ? LEN_TWO : LEN_ONE)) else $error("immediate length wrong");
  acc_size_a: assert property (take_first({ALU_TOP, FN_ADC, ALU_ACC_LOW, 1'b1}) ##1 (fetch.valid && state_reg == st_tail)[*2] |=> dec_valid && dec.word && dec.imm_len == LEN_TWO) else $error("word size ignored");

endmodule : cpu_opcode_decoder

`default_nettype wire

/* verif/fetch_source.sv */
// Fetch path model: hands queued bytes to the decoder in program order.
// Assumes the bench pushes whole instructions; gaps are optional and random.
`timescale 1ns/1ns
`default_nettype none

module fetch_source
  import opdec_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic gap_en,
  output var fetch_t fetch
);
  logic [7:0] q[$];

  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask : push

  initial fetch = '0;

  // Idle data is inverted so a stale byte never looks like a live one
  always @(negedge mclk) begin
    if (rst || q.size() == 0 || (gap_en && $urandom_range(0, 2) == 0)) begin
      fetch.valid <= 1'b0;
      fetch.data <= ~fetch.data;
    end else begin
      fetch.valid <= 1'b1;
      fetch.data <= q.pop_front();
    end
  end
endmodule : fetch_source

`default_nettype wire

/* verif/cpu_opcode_decoder_tb.sv */
// Self-checking bench: a byte-level model predicts every decode and its timing.
// Assumes the fetch model delivers bytes in order, one per cycle at most.
`timescale 1ns/1ns
`default_nettype none

module cpu_opcode_decoder_tb
  import opdec_pkg::*;
;
  logic mclk;
  logic rst;
  logic gap_en;
  logic busy;
  logic dec_valid;
  fetch_t fetch;
  decode_t dec;
  decode_t exp_q[$];
  int len_q[$];
  int rem, due, n_mismatch, num_checks, i, k;
  logic [7:0] ops[$];

  cpu_opcode_decoder i_cpu_opcode_decoder(.mclk(mclk), .rst(rst), .fetch(fetch), .busy(busy),
    .dec_valid(dec_valid), .dec(dec));
  fetch_source i_fetch_source(.mclk(mclk), .rst(rst), .gap_en(gap_en), .fetch(fetch));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [15:0] ex, input logic [15:0] got);
    num_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, ex, got);
    end
  endtask : chk

  function automatic int predict(input logic [7:0] b[$], output decode_t e);
    op_t md[8] = '{no_op_decoded, no_op_decoded, invert_op, negate_op, unsigned_product_op,
      signed_product_op, unsigned_quotient_op, signed_quotient_op};
    logic [7:0] o;
    logic [7:0] m;
    logic [2:0] f;
    logic hm;
    int p, dl, il;
    e = '0;
    o = b[0];
    m = b[1];
    f = m[5:3];
    il = 0;
    e.opcode = o;
    e.word = o[0];
    e.count_cl = o[1];
    e.dir = o[1];
    e.sign_ext = o[1];
    e.seg_sel = m[4:3];
    e.op = alu_op;
    case (o) inside
      8'hD7: e.op = table_lookup_op;
      8'h9F: e.op = flags_to_acc_high;
      8'h9E: e.op = acc_high_to_flags;
      8'h37: e.op = ascii_sum_fix;
      8'h27: e.op = bcd_sum_fix;
      8'h3F: e.op = ascii_diff_fix;
      8'h2F: e.op = bcd_diff_fix;
      8'h98: e.op = byte_to_word_extend;
      8'h99: e.op = word_to_double_extend;
      8'h8E: e.op = copy_seg_load;
      8'h8C: e.op = copy_seg_store;
      8'h8D: e.op = eff_address_load_op;
      8'hC5: e.op = pointer_load_data_seg;
      8'hC4: e.op = pointer_load_extra_seg;
      8'hD4: e.op = ascii_product_fix;
      8'hD5: e.op = ascii_quotient_fix;
      [8'h10:8'h15], [8'h18:8'h1D], [8'h80:8'h83]: begin
        e.alu_fn = o[7] ? f : {2'b01, o[3]};
        e.illegal = o[7] && (f inside {1, 4, 6});
      end
      8'hF6, 8'hF7: begin
        e.op = md[f];
        e.illegal = (f < 2);
      end
      [8'hD0:8'hD3]: begin
        e.op = f[0] ? logical_right_shift_op : left_shift_op;
        e.illegal = (f[2:1] != 2'b10);
      end
      default: e.illegal = 1'b1;
    endcase
    hm = (o inside {[8'h10:8'h13], [8'h18:8'h1B], [8'h80:8'h83], [8'h8C:8'h8E], 8'hC4, 8'hC5,
      [8'hD0:8'hD3], 8'hF6, 8'hF7});
    e.has_modrm = hm;
    e.modrm = (hm || o inside {8'hD4, 8'hD5}) ? m : 8'h00;
    if (o inside {8'h8C, 8'h8E}) e.illegal = m[5];
    if (o inside {8'hD4, 8'hD5}) e.illegal = (m != 8'h0A);
    if (o inside {[8'h14:8'h15], [8'h1C:8'h1D]}) il = 1 + o[0];
    if (o inside {[8'h80:8'h83]}) il = (o[1:0] == 2'b01) ? 2 : 1;
    if (!hm && il == 0) e.word = (o == 8'h99);
    if (o inside {[8'h8C:8'h8E], 8'hC4, 8'hC5}) e.word = 1'b1;
    p = (hm || o inside {8'hD4, 8'hD5}) ? 2 : 1;
    dl = !hm ? 0 : (m[7:6] == 2'b01) ? 1 : (m[7:6] == 2'b10 || (m[7:6] == 2'b00 && m[2:0] == 3'h6)) ? 2 : 0;
    e.disp_len = 2'(dl);
    e.disp = {b[p + 1], b[p]};
    p = p + dl;
    e.imm_len = 2'(il);
    e.imm = (il == 2) ? {b[p + 1], b[p]} : (o[1:0] == 2'b11) ? {{8{b[p][7]}}, b[p]} : {8'h00, b[p]};
    return p + il;
  endfunction : predict

  function automatic logic [7:0] mk(input logic [2:0] f);
    return {2'($urandom), f, 3'($urandom)};
  endfunction : mk

  task automatic send(input logic [7:0] o, input logic [7:0] m);
    logic [7:0] b[$];
    decode_t e;
    int n;
    b = {o, m};
    repeat (6) b.push_back(8'($urandom));
    n = predict(b, e);
    exp_q.push_back(e);
    len_q.push_back(n);
    for (int j = 0; j < n; j++) i_fetch_source.push(b[j]);
  endtask : send

  task automatic cmp(input decode_t e);
    chk("illegal", 16'(e.illegal), 16'(dec.illegal));
    if (!e.illegal) begin
      chk("op", 16'(e.op), 16'(dec.op));
      if (!(e.opcode inside {8'hD4, 8'hD5})) chk("word", 16'(e.word), 16'(dec.word));
      if (e.op == alu_op) chk("alu_fn", 16'(e.alu_fn), 16'(dec.alu_fn));
      if (e.op == alu_op) chk("dir", 16'(e.dir), 16'(dec.dir));
      if (e.opcode[7:2] == IMM_GRP) chk("sign_ext", 16'(e.sign_ext), 16'(dec.sign_ext));
      chk("has_modrm", 16'(e.has_modrm), 16'(dec.has_modrm));
      chk("modrm", 16'(e.modrm), 16'(dec.modrm));
      if (e.op inside {left_shift_op, logical_right_shift_op}) chk("count_cl", 16'(e.count_cl), 16'(dec.count_cl));
      if (e.op inside {copy_seg_load, copy_seg_store}) chk("seg_sel", 16'(e.seg_sel), 16'(dec.seg_sel));
      chk("imm_len", 16'(e.imm_len), 16'(dec.imm_len));
      chk("disp_len", 16'(e.disp_len), 16'(dec.disp_len));
      if (e.imm_len != 0) chk("imm", e.imm, dec.imm);
      if (e.disp_len == 2) chk("disp", e.disp, dec.disp);
      if (e.disp_len == 1) chk("disp_low", 16'(e.disp[7:0]), 16'(dec.disp[7:0]));
    end
  endtask : cmp

  // Tracks bytes taken per instruction so the answer cycle is checked exactly
  always @(posedge mclk) begin
    if (rst) begin
      rem = 0;
      due = 0;
    end else begin
      chk("busy", 16'(rem != 0), 16'(busy));
      chk("dec_valid", 16'(due), 16'(dec_valid));
      if (dec_valid === 1'b1 && exp_q.size() != 0) cmp(exp_q.pop_front());
      due = 0;
      if (fetch.valid && len_q.size() + rem != 0) begin
        if (rem == 0) rem = len_q.pop_front();
        rem--;
        due = (rem == 0);
      end
    end
  end

  task automatic drain(input string name);
    k = 0;
    while (exp_q.size() != 0 && k < 3000) begin
      @(posedge mclk);
      k++;
    end
    chk("pending", 16'h0000, 16'(exp_q.size()));
    $display("test %s done", name);
  endtask : drain

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    #(50 * 40000);
    n_mismatch++;
    summarize();
  end

  initial begin
    void'($urandom(47221));
    rst = 1'b1;
    gap_en = 1'b0;
    repeat (12) @(negedge mclk);
    chk("reset_dec", 16'h0000, 16'(dec !== '0));
    rst = 1'b0;
    ops = '{8'hD7, 8'h9F, 8'h9E, 8'h37, 8'h27, 8'h3F, 8'h2F, 8'h98, 8'h99};
    foreach (ops[j]) send(ops[j], 8'($urandom));
    ops = '{8'h8E, 8'h8C, 8'h8D, 8'hC5, 8'hC4};
    for (i = 0; i < 20; i++) send(ops[i % 5], mk({1'b0, 2'(i)}));
    send(8'hD4, 8'h0A);
    send(8'hD5, 8'h0A);
    drain("fixed_ops");
    ops = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h14, 8'h15, 8'h1C, 8'h1D};
    for (i = 0; i < 48; i++) send(ops[i % 12], mk(3'($urandom)));
    for (i = 0; i < 40; i++) send(8'h80 + 8'(i % 4), mk(3'(i / 4 % 8)));
    drain("arith");
    for (i = 0; i < 24; i++) send(8'hF6 + 8'(i % 2), mk(3'(2 + i / 2 % 6)));
    for (i = 0; i < 32; i++) send(8'hD0 + 8'(i % 4), mk(3'(i / 4 % 8)));
    drain("muldiv_shift");
    send(8'h8E, mk(3'h5));
    send(8'h8C, mk(3'h4));
    send(8'hD4, 8'h0B);
    send(8'hD5, 8'h00);
    send(8'hF4, 8'h00);
    send(8'hC3, 8'h00);
    drain("refused");
    gap_en = 1'b1;
    ops = '{8'hD7, 8'h98, 8'h99, 8'h8E, 8'h8D, 8'hC4, 8'h12, 8'h15, 8'h1C, 8'h81, 8'h83, 8'hF7, 8'hD3, 8'hD4};
    for (i = 0; i < 80; i++) send(ops[$urandom_range(0, ops.size() - 1)], 8'($urandom));
    drain("gaps");
    summarize();
  end
endmodule : cpu_opcode_decoder_tb

`default_nettype wire
